// ### eic_core.sv
// Encoder position counter with control register, index, home and compare initialisation.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "eic_map.svh"
module eic_core #(
   parameter int CNT_W = 32
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   input  wire logic        phase_a_input_i,
   input  wire logic        phase_b_input_i,
   input  wire logic        index_i,
   input  wire logic        home_i,
   input  wire logic        idle_i,
   output logic      [CNT_W-1:0] position_o,
   output logic        active_o
);
   // ************************************************************
   // Registers
   // ************************************************************
   logic [15:0]      ctrl_r, ctrl_nxt;
   logic [CNT_W-1:0] init_r, init_nxt;
   logic [CNT_W-1:0] gec_r, gec_nxt;
   logic [CNT_W-1:0] pos_r, pos_nxt;
   logic [15:0]      rdata_r, rdata_nxt;
   logic             a_q_r, b_q_r, idx_q_r, home_q_r;
   logic             idx_d_r, home_d_r;
   logic             load_done_r, load_done_nxt;
   logic [1:0]       home_cnt_r, home_cnt_nxt;
   eic_pkg::eic_arm_type arm_r, arm_nxt;
   logic             active_r, active_nxt;

   eic_pkg::eic_pis_type pis;
   logic [1:0]       count_mode_select;
   logic             run, idx_rise, home_rise, idx_match, step_dir, quad_step;
   logic             a_p_r;
   logic             load_evt;

   // Field views of the control word; the enum cast keeps the case labels readable.
   assign pis = eic_pkg::eic_pis_type'(ctrl_r[`EIC_PIS_HI:`EIC_PIS_LO]);
   assign count_mode_select = ctrl_r[`EIC_CCM_HI:`EIC_CCM_LO];

   // Block runs only while enabled and not halted by idle.
   assign run = ctrl_r[`EIC_BIT_COUNTERS_ON] & ~(ctrl_r[`EIC_BIT_HALT_IDLE] & idle_i);

   // Edge detection on registered pins, one clock of latency by design.
   assign idx_rise  = idx_q_r & ~idx_d_r;
   assign home_rise = home_q_r & ~home_d_r;

   // Phase levels must match the programmed match bits.
   assign idx_match = (b_q_r == ctrl_r[`EIC_BIT_IMV_B])
                    & (a_q_r == ctrl_r[`EIC_BIT_IMV_A]);

   // Simple x2 quadrature step taken on both rising and falling phase A transitions.
   assign quad_step = (a_q_r ^ a_p_r);
   assign step_dir  = a_q_r ^ b_q_r;

   // ************************************************************
   // Input sampling
   // ************************************************************
   // Inputs are taken as synchronous; one stage aligns them to the edge detector.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         a_q_r    <= 1'b0;
         b_q_r    <= 1'b0;
         idx_q_r  <= 1'b0;
         home_q_r <= 1'b0;
         idx_d_r  <= 1'b0;
         home_d_r <= 1'b0;
         a_p_r    <= 1'b0;
      end else begin
         a_q_r    <= phase_a_input_i;
         b_q_r    <= phase_b_input_i;
         idx_q_r  <= index_i;
         home_q_r <= home_i;
         idx_d_r  <= idx_q_r;
         home_d_r <= home_q_r;
         a_p_r    <= a_q_r;
      end
   end

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Bus writes take priority over counting on the position registers.
   always_comb begin
      ctrl_nxt      = ctrl_r;
      init_nxt      = init_r;
      gec_nxt       = gec_r;
      pos_nxt       = pos_r;
      load_done_nxt = load_done_r;
      home_cnt_nxt  = home_cnt_r;
      arm_nxt       = arm_r;
      load_evt      = 1'b0;
      if (run) begin
         if (count_mode_select[1]) begin
            // Timer modes count every cycle and bypass init select entirely.
            pos_nxt = pos_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end else begin
            if (quad_step) begin
               if (step_dir) begin
                  pos_nxt = pos_r + {{(CNT_W-1){1'b0}}, 1'b1};
               end else begin
                  pos_nxt = pos_r - {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            case (pis)
               eic_pkg::EIC_PIS_NONE: begin
                  pos_nxt = pos_nxt;
               end
               eic_pkg::EIC_PIS_RESET_IDX: begin
                  if (idx_rise) begin
                     pos_nxt = '0;
                  end
               end
               eic_pkg::EIC_PIS_LOAD_NEXT: begin
                  // One-shot: the done flag blocks later index edges until control is rewritten.
                  if (idx_rise && !load_done_r) begin
                     pos_nxt       = init_r;
                     load_done_nxt = 1'b1;
                     load_evt      = 1'b1;
                  end
               end
               eic_pkg::EIC_PIS_LOAD_HOME1, eic_pkg::EIC_PIS_LOAD_HOME2: begin
                  // Home arms; index edges are counted until the selected one loads.
                  case (arm_r)
                     eic_pkg::EIC_ARM_IDLE: begin
                        if (home_rise) begin
                           arm_nxt      = eic_pkg::EIC_ARM_WAIT;
                           home_cnt_nxt = 2'h0;
                        end
                     end
                     eic_pkg::EIC_ARM_WAIT: begin
                        if (idx_rise) begin
                           // The count holds the index edges already passed since home.
                           if ((pis == eic_pkg::EIC_PIS_LOAD_HOME1) ||
                               (home_cnt_r == (`EIC_HOME_CNT_MAX - 2'h1))) begin
                              pos_nxt = init_r;
                              arm_nxt = eic_pkg::EIC_ARM_DONE;
                           end else begin
                              home_cnt_nxt = home_cnt_r + 2'h1;
                           end
                        end
                     end
                     eic_pkg::EIC_ARM_DONE: begin
                        if (home_rise) begin
                           arm_nxt      = eic_pkg::EIC_ARM_WAIT;
                           home_cnt_nxt = 2'h0;
                        end
                     end
                     default: begin
                        arm_nxt = eic_pkg::EIC_ARM_IDLE;
                     end
                  endcase
               end
               eic_pkg::EIC_PIS_RESET_GE: begin
                  // Checked every cycle, so a count parked on the compare value stays at zero.
                  if (pos_r == gec_r) begin
                     pos_nxt = '0;
                  end
               end
               eic_pkg::EIC_PIS_MODULO: begin
                  // Wraps between zero and the compare value in both directions.
                  // Only single steps are seen, so a bus write past the limit does not wrap.
                  if (quad_step && step_dir && (pos_r == gec_r)) begin
                     pos_nxt = '0;
                  end else if (quad_step && !step_dir && (pos_r == '0)) begin
                     pos_nxt = gec_r;
                  end
               end
               eic_pkg::EIC_PIS_RSVD: begin
                  // Reserved code: software must not select it; init select leaves the count alone, but an index match still clears it.
                  pos_nxt = pos_nxt;
               end
               default: begin
                  pos_nxt = pos_nxt;
               end
            endcase
            // Index match is applied last so that it wins over any init-select action.
            if ((count_mode_select == 2'b00) && idx_rise && idx_match) begin
               pos_nxt = '0;
            end
         end
      end
      // Writes land at the next edge; position writes override any count made in the same cycle.
      if (wr_i) begin
         case (addr_i)
            `EIC_OFS_CONTROL: begin
               ctrl_nxt      = wdata_i & `EIC_CTRL_WMASK;
               // A load in the same cycle as the rewrite wins, so one index never loads twice.
               load_done_nxt = load_evt;
               arm_nxt       = eic_pkg::EIC_ARM_IDLE;
            end
            `EIC_OFS_INIT_VALUE: init_nxt = {{(CNT_W-16){1'b0}}, wdata_i};
            `EIC_OFS_GE_COMPARE: gec_nxt  = {{(CNT_W-16){1'b0}}, wdata_i};
            `EIC_OFS_POS_LOW:    pos_nxt  = {pos_r[CNT_W-1:16], wdata_i};
            `EIC_OFS_POS_HIGH:   pos_nxt  = {wdata_i, pos_r[15:0]};
            default: begin
               ctrl_nxt = ctrl_nxt;
            end
         endcase
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************
   // Registered outputs keep every top-level output glitch free.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r      <= `EIC_CTRL_RESET;
         init_r      <= '0;
         gec_r       <= '0;
         pos_r       <= '0;
         load_done_r <= 1'b0;
         home_cnt_r  <= 2'h0;
         arm_r       <= eic_pkg::EIC_ARM_IDLE;
      end else begin
         ctrl_r      <= ctrl_nxt;
         init_r      <= init_nxt;
         gec_r       <= gec_nxt;
         pos_r       <= pos_nxt;
         load_done_r <= load_done_nxt;
         home_cnt_r  <= home_cnt_nxt;
         arm_r       <= arm_nxt;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Read data stand for one cycle only and fall back to zero, so a late sample sees nothing stale.
   always_comb begin
      rdata_nxt = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            `EIC_OFS_CONTROL:    rdata_nxt = ctrl_r;
            `EIC_OFS_INIT_VALUE: rdata_nxt = init_r[15:0];
            `EIC_OFS_GE_COMPARE: rdata_nxt = gec_r[15:0];
            `EIC_OFS_POS_LOW:    rdata_nxt = pos_r[15:0];
            `EIC_OFS_POS_HIGH:   rdata_nxt = pos_r[31:16];
            `EIC_OFS_STATUS:     rdata_nxt = {12'h000, load_done_r, arm_r, run};
            default:             rdata_nxt = 16'h0000;
         endcase
      end
   end

   // The read register stays clear while the block is held in reset.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ************************************************************
   // Activity flag
   // ************************************************************
   // Mirrors the run condition one cycle late; software polls it to see an idle halt take hold.
   always_comb begin
      active_nxt = run;
   end

   // Kept as a flop so the output never glitches while idle toggles.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Every output is a plain wire from a flop; no logic sits after the registers.
   assign rdata_o    = rdata_r;
   assign position_o = pos_r;
   assign active_o   = active_r;
endmodule : eic_core
`default_nettype wire

// ### eic_map.svh
// Register offsets, field positions, reset values and widths of the encoder position init control block.
`ifndef EIC_MAP_SVH
`define EIC_MAP_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define EIC_OFS_CONTROL      4'h0
`define EIC_OFS_INIT_VALUE   4'h1
`define EIC_OFS_GE_COMPARE   4'h2
`define EIC_OFS_POS_LOW      4'h3
`define EIC_OFS_POS_HIGH     4'h4
`define EIC_OFS_STATUS       4'h5
// ************************************************************
// Control register fields
// ************************************************************
`define EIC_BIT_COUNTERS_ON  15
`define EIC_BIT_HALT_IDLE    13
`define EIC_PIS_HI           12
`define EIC_PIS_LO           10
`define EIC_BIT_IMV_B        9
`define EIC_BIT_IMV_A        8
`define EIC_CTRL_WMASK       16'hBF7F
`define EIC_CTRL_RESET       16'h0000
`define EIC_CCM_HI           1
`define EIC_CCM_LO           0
`define EIC_HOME_CNT_MAX     2'h2
`endif

// ### eic_pkg.sv
// Types of the encoder position init control block.
package eic_pkg;
   // ************************************************************
   // Position init select codes
   // ************************************************************
   typedef enum logic [2:0] {
      EIC_PIS_NONE      = 3'b000,
      EIC_PIS_RESET_IDX = 3'b001,
      EIC_PIS_LOAD_NEXT = 3'b010,
      EIC_PIS_LOAD_HOME1 = 3'b011,
      EIC_PIS_LOAD_HOME2 = 3'b100,
      EIC_PIS_RESET_GE  = 3'b101,
      EIC_PIS_MODULO    = 3'b110,
      EIC_PIS_RSVD      = 3'b111
   } eic_pis_type;
   // ************************************************************
   // Home and index arming states
   // ************************************************************
   typedef enum logic [1:0] {
      EIC_ARM_IDLE  = 2'b00,
      EIC_ARM_WAIT  = 2'b01,
      EIC_ARM_DONE  = 2'b10
   } eic_arm_type;
endpackage : eic_pkg

// ### eic_core_monitor.sv
// Property checker that watches the ports of the encoder position init control block.
`timescale 1ns/10ps
`default_nettype none
module eic_mon #(parameter int CNT_W = 32) (
   input wire logic             clk_sys_i,
   input wire logic             rst_i,
   input wire logic [3:0]       addr_i,
   input wire logic [15:0]      wdata_i,
   input wire logic             wr_i,
   input wire logic             rd_i,
   input wire logic [15:0]      rdata_o,
   input wire logic             phase_a_input_i,
   input wire logic             phase_b_input_i,
   input wire logic             index_i,
   input wire logic             idle_i,
   input wire logic [CNT_W-1:0] position_o,
   input wire logic             active_o
);
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic        run;
   logic        qd;
   logic        run_want;
   // Shadow of the control word; the ports alone cannot show which mode is in force.
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_i && addr_i == 4'h0) ctrl_nxt = wdata_i & 16'hBF7F;
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) ctrl_r <= 16'h0000;
      else ctrl_r <= ctrl_nxt;
   end
   // Counting is only expected once the active flag has followed the control word.
   assign run_want = ctrl_r[15] && !(ctrl_r[13] && idle_i);
   assign run = run_want && active_o;
   assign qd = run && ctrl_r[1:0] == 2'b01;
   default clocking dc @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   AST_RD_QUIET: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("Read data not zero outside a read.");
   AST_CTRL_RD: assert property (rd_i && addr_i == 4'h0 |=> rdata_o == $past(ctrl_r))
      else $error("Control word read back wrong.");
   AST_UNMAP: assert property (rd_i && addr_i > 4'h5 |=> rdata_o == 16'h0000)
      else $error("Unmapped read not zero.");
   AST_ACTIVE: assert property (1'b1 |=> active_o == $past(run_want))
      else $error("Active flag wrong.");
   AST_OFF_HOLD: assert property ((!ctrl_r[15] && !wr_i) [*2] |=> $stable(position_o))
      else $error("Position moved while off.");
   AST_TIMER: assert property ((run && ctrl_r[1] && !wr_i) [*2] |=> position_o == $past(position_o) + 1'b1)
      else $error("Timer did not step by one.");
   AST_IDX_RST: assert property (qd && ctrl_r[12:10] == 3'b001 && $rose(index_i) |->
      ##[1:4] position_o == '0)
      else $error("Index did not clear position.");
   AST_IDX_MATCH: assert property (run && ctrl_r[1:0] == 2'b00 && $rose(index_i) &&
      phase_a_input_i == ctrl_r[8] && phase_b_input_i == ctrl_r[9] |-> ##[1:4] position_o == '0)
      else $error("Index match did not clear position.");
endmodule : eic_mon
bind eic_core eic_mon #(.CNT_W(CNT_W)) i_eic_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .phase_a_input_i(phase_a_input_i),
   .phase_b_input_i(phase_b_input_i), .index_i(index_i), .idle_i(idle_i), .position_o(position_o),
   .active_o(active_o));
`default_nettype wire

// ### eic_enc.sv
// Behavioural rotary encoder with two phase levels, an index mark and a home mark.
`timescale 1ns/10ps
`default_nettype none
module eic_enc (
   input  wire logic clk_sys_i,
   output logic      phase_a_o,
   output logic      phase_b_o,
   output logic      index_o,
   output logic      home_o
);
   // The shaft rests with every line low.
   initial begin
      {phase_a_o, phase_b_o, index_o, home_o} = 4'h0;
   end
   // Levels change only just after an edge, as a real sensor sampled by the block would.
   task automatic set_phases(input logic a, input logic b);
      @(posedge clk_sys_i);
      phase_a_o <= a;
      phase_b_o <= b;
   endtask : set_phases
   // A mark lasts one to three cycles, as a slow shaft holds it, then the shaft settles.
   task automatic pulse(input logic home);
      @(posedge clk_sys_i);
      index_o <= !home;
      home_o <= home;
      repeat (1 + $urandom_range(2)) @(posedge clk_sys_i);
      {index_o, home_o} <= 2'b00;
      repeat (4) @(posedge clk_sys_i);
   endtask : pulse
endmodule : eic_enc
`default_nettype wire

// ### eic_core_tb.sv
// Self-checking bench of the encoder position init control block.
`timescale 1ns/10ps
`default_nettype none
module eic_core_tb;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        idle_i = 1'b0;
   logic [15:0] rdata_o, d, c;
   logic [31:0] position_o, s;
   logic        active_o, pa, pb, idx, hm;
   int          n_fail = 0;
   int          checks_done = 0;
   // Clock of 10 ns period.
   always #5 clk_sys_i = ~clk_sys_i;
   eic_core i_eic_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .phase_a_input_i(pa), .phase_b_input_i(pb), .index_i(idx), .home_i(hm),
      .idle_i(idle_i), .position_o(position_o), .active_o(active_o));
   eic_enc i_eic_enc (.clk_sys_i(clk_sys_i), .phase_a_o(pa), .phase_b_o(pb), .index_o(idx), .home_o(hm));
   // Bus cycles: one strobe cycle each, read data taken in the cycle after the strobe.
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : bus_rd
   task automatic set_pos(input logic [31:0] v);
      bus_wr(4'h3, v[15:0]);
      bus_wr(4'h4, v[31:16]);
   endtask : set_pos
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pos(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t position got %h expected %h", $time, got, exp);
      end
   endtask : chk_pos
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // Expected position after marks H (home), I (index) and W (position rewritten to the start value).
   function automatic logic [31:0] exp_pos(input logic [2:0] m, input string ev, input logic [31:0] p0,
      input logic [15:0] iv);
      logic [31:0] p = p0;
      int n = 0;
      bit homed = 0;
      bit used = 0;
      for (int i = 0; i < ev.len(); i++) begin
         if (ev[i] == "H") begin
            homed = 1;
            n = 0;
         end else if (ev[i] == "W") begin
            p = p0;
         end else begin
            n++;
            if (m == 3'b001) p = 32'h0;
            if ((m == 3'b010 && !used) || (homed && ((m == 3'b011 && n == 1) || (m == 3'b100 && n == 2))))
               p = {16'h0000, iv};
            used = 1;
         end
      end
      return p;
   endfunction : exp_pos
   task automatic run_mode(input logic [2:0] m, input string ev);
      logic [31:0] p;
      logic [15:0] iv;
      p = $urandom | 32'h0001_0001;
      iv = 16'($urandom);
      bus_wr(4'h0, 16'h0000);
      set_pos(p);
      bus_wr(4'h1, iv);
      bus_wr(4'h0, {3'b100, m, 10'h001});
      for (int i = 0; i < ev.len(); i++) begin
         if (ev[i] == "W") set_pos(p);
         else i_eic_enc.pulse(ev[i] == "H");
      end
      #1 chk_pos(position_o, exp_pos(m, ev, p, iv));
   endtask : run_mode
   // Main sequence: register map, enable and idle control, compare reset, index match, init select codes.
   initial begin
      void'($urandom(52720));
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      bus_rd(4'h0, d);
      chk_reg(d, 16'h0000);
      bus_wr(4'h0, 16'hFFFF);
      bus_rd(4'h0, d);
      chk_reg(d, 16'hBF7F);
      for (int a = 6; a < 16; a++) begin
         bus_wr(4'(a), 16'hFFFF);
         bus_rd(4'(a), d);
         chk_reg(d, 16'h0000);
      end
      bus_wr(4'h0, 16'h8402);
      i_eic_enc.pulse(1'b0);
      bus_wr(4'h0, 16'hA002);
      idle_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 s = position_o;
      repeat (4) @(posedge clk_sys_i);
      #1 chk_pos(position_o, s);
      chk_reg({15'h0000, active_o}, 16'h0000);
      bus_wr(4'h0, 16'h8002);
      repeat (2) @(posedge clk_sys_i);
      #1 chk_reg({15'h0000, active_o}, 16'h0001);
      bus_wr(4'h0, 16'h0002);
      s = $urandom | 32'h0001_0001;
      set_pos(s);
      bus_rd(4'h4, d);
      chk_reg(d, s[31:16]);
      repeat (5) @(posedge clk_sys_i);
      #1 chk_pos(position_o, s);
      c = 16'($urandom);
      bus_wr(4'h2, c);
      for (int k = 0; k < 2; k++) begin
         bus_wr(4'h0, 16'h0000);
         set_pos({16'h0000, c ^ 16'(k)});
         bus_wr(4'h0, 16'h9401);
         repeat (4) @(posedge clk_sys_i);
         #1 chk_pos(position_o, k ? {16'h0000, c ^ 16'h0001} : 32'h0);
      end
      for (int k = 0; k < 16; k++) begin
         s = $urandom | 32'h0001_0001;
         bus_wr(4'h0, 16'h0000);
         i_eic_enc.set_phases(k[0], k[1]);
         set_pos(s);
         bus_wr(4'h0, {6'b100000, k[3:2], 8'h00});
         i_eic_enc.pulse(1'b0);
         #1 chk_pos(position_o, (k[1:0] == k[3:2]) ? 32'h0 : s);
      end
      run_mode(3'b000, "IHI");
      run_mode(3'b001, "WII");
      run_mode(3'b010, "IWI");
      run_mode(3'b011, "HI");
      run_mode(3'b011, "IHIWI");
      run_mode(3'b100, "HIWI");
      // Modulo wrap: one step up from the limit lands on zero, one step down from zero on the limit.
      bus_wr(4'h0, 16'h0000);
      i_eic_enc.set_phases(1'b1, 1'b1);
      set_pos({16'h0000, c});
      bus_wr(4'h0, 16'h9801);
      i_eic_enc.set_phases(1'b0, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      #1 chk_pos(position_o, 32'h0);
      i_eic_enc.set_phases(1'b1, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      #1 chk_pos(position_o, {16'h0000, c});
      close_out();
   end
   // Watchdog: the sequence needs well under this many cycles.
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_fail++;
      close_out();
   end
endmodule : eic_core_tb
`default_nettype wire
